/* File: hw/rtcbcd_pkg.sv */
package rtcbcd_pkg;
  // ==========================================
  // register map (byte addresses)
  localparam logic [7:0] ADDR_TIME = 8'h00;
  localparam logic [7:0] ADDR_DATE = 8'h04;
  localparam logic [7:0] ADDR_SUBSEC = 8'h08;
  localparam logic [7:0] ADDR_CTRL = 8'h0C;
  localparam logic [7:0] ADDR_SETUP = 8'h10;
  localparam logic [7:0] ADDR_PRESC = 8'h14;
  localparam logic [7:0] ADDR_KEY = 8'h18;
  // ==========================================
  // protection keys
  localparam logic [7:0] KEY_FIRST = 8'hCA;
  localparam logic [7:0] KEY_SECOND = 8'h53;
  localparam logic [7:0] KEY_LOCK = 8'hFF;
  // ==========================================
  // control register fields
  localparam int CTRL_FMT = 0;
  localparam int CTRL_ADD1H = 1;
  localparam int CTRL_SUB1H = 2;
  localparam int CTRL_SRC_LSB = 4;
  localparam int CTRL_HDIV_LSB = 8;
  // ==========================================
  // setup status register fields
  localparam int SET_INIT = 0;
  localparam int SET_FLAG = 1;
  localparam int SET_LOW_POWER_CALIB_SELECT = 2;
  localparam int SET_UNLOCK = 3;
  localparam int SET_BIN_LSB = 4;
  localparam int SET_MIX_LSB = 8;
  // ==========================================
  // prescaler register fields and reset values
  localparam int PRE_SYNC_LSB = 0;
  localparam int PRE_ASYNC_LSB = 16;
  localparam logic [14:0] SYNC_DIV_RST = 15'h00FF;
  localparam logic [6:0] ASYNC_DIV_RST = 7'h7F;
  localparam logic [6:0] ASYNC_DIV_MIN = 7'h01;
  // ==========================================
  // time and date register fields
  localparam int T_SEC_LSB = 0;
  localparam int T_MIN_LSB = 8;
  localparam int T_HOUR_LSB = 16;
  localparam int T_PM = 22;
  localparam int D_DATE_LSB = 0;
  localparam int D_MON_LSB = 8;
  localparam int D_WDAY_LSB = 13;
  localparam int D_YEAR_LSB = 16;
  // ==========================================
  // bcd limits
  localparam logic [7:0] BCD_ZERO = 8'h00;
  localparam logic [7:0] MINSEC_MAX = 8'h59;
  localparam logic [7:0] HOUR24_MAX = 8'h23;
  localparam logic [7:0] HOUR12_FIRST = 8'h01;
  localparam logic [7:0] HOUR12_LAST = 8'h11;
  localparam logic [7:0] HOUR12_MAX = 8'h12;
  localparam logic [7:0] DATE_MIN = 8'h01;
  localparam logic [7:0] MON_MIN = 8'h01;
  localparam logic [7:0] MON_MAX = 8'h12;
  localparam logic [7:0] WDAY_MIN = 8'h01;
  localparam logic [7:0] WDAY_MAX = 8'h07;
  localparam logic [7:0] YEAR_MAX = 8'h99;
  // ==========================================
  // handshake timing in source / async ticks
  localparam logic [2:0] ENTER_TICKS = 3'h2;
  localparam logic [2:0] LEAVE_TICKS = 3'h4;
  localparam logic [2:0] LEAVE_LP_TICKS = 3'h2;
  // ==========================================
  // modes and sources
  localparam logic [1:0] BIN_OFF = 2'h0;
  localparam logic [1:0] BIN_ONLY = 2'h1;
  localparam logic [5:0] MIX_BASE = 6'h07;
  localparam logic [31:0] BIN_RELOAD = 32'hFFFF_FFFF;
  localparam logic [1:0] SRC_LSE = 2'h1;
  localparam logic [1:0] SRC_LSI = 2'h2;
  localparam logic [1:0] SRC_HSE = 2'h3;

  typedef enum logic [1:0] {ST_RUN, ST_ENTER, ST_SETUP, ST_LEAVE} rtcbcd_state_t;

  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction

  function automatic logic [7:0] bcd_dec(input logic [7:0] v);
    bcd_dec = (v[3:0] == 4'h0) ? {v[7:4] - 4'h1, 4'h9} : {v[7:4], v[3:0] - 4'h1};
  endfunction

  // two-digit bcd year: leap every fourth year
  function automatic logic [7:0] month_last(input logic [7:0] m, input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    case (m)
      8'h02: month_last = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_last = 8'h30;
      default: month_last = 8'h31;
    endcase
  endfunction
endpackage

/* File: hw/rtcbcd_bcd_cnt.sv */
`timescale 1ns/100ps
module rtcbcd_bcd_cnt #(
  parameter logic [7:0] MINV = 8'h00,
  parameter logic [7:0] MAXV = 8'h59
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // control
  input wire logic load,
  input wire logic [7:0] load_val,
  input wire logic inc,
  // state
  output logic [7:0] value_q,
  output logic wrap
);
  assign wrap = inc && (value_q == MAXV);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      value_q <= MINV;
    end
    else if (load)
    begin
      value_q <= load_val;
    end
    else if (inc)
    begin
      value_q <= wrap ? MINV : rtcbcd_pkg::bcd_inc(value_q);
    end
  end
endmodule

/* File: hw/rtcbcd_core.sv */
`timescale 1ns/100ps
// Notes on behaviour
// - bcd calendar subsec to year, 12/24h
// - month lengths and leap years handled
// - software add or subtract one hour
// - subsecond reads synchronous prescaler count
// - binary mode reads pclk-clocked counter of async ticks
// - binary-only mode disables bcd calendar
// - unlock by keys CA then 53
// - key FF locks registers again
// - setup request stops calendar counting
// - setup flag after two ticks
// - prescaler resets to 1 Hz at 32768
// - format bit selects 24h or 12h
// - leaving setup loads shadows, resumes counting
// - two-bit select picks one of three sources
// - high-speed source gets extra pre-division
// - tick is source over both dividers when binary mode is off
// - async divider 1 to 127, 7 bits
// - sync divider 0 to 32767, 15 bits
// - calendar advances on pclk domain
module rtcbcd_core (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // source clock pins
  input wire logic lse_clk,
  input wire logic lsi_clk,
  input wire logic hse_clk,
  // status
  output logic one_hz_tick
);
  // ==========================================
  // declarations
  rtcbcd_pkg::rtcbcd_state_t state_q;
  logic [2:0] sync1_q, sync2_q, sync3_q, lvl_q, lvl_d, rise;
  logic [4:0] hse_cnt_q;
  logic src_tick, async_tick, mix_tick;
  logic [6:0] async_div_q, async_cnt_q;
  logic [14:0] sync_div_q, sync_cnt_q;
  logic [31:0] bin_cnt_q, mix_mask;
  logic unlocked_q, key1_q, init_q, low_power_calib_select_q, fmt_q;
  logic [1:0] src_sel_q, bin_sel_q;
  logic [2:0] mix_sel_q;
  logic [4:0] hse_div_q;
  logic add1h_q, sub1h_q;
  logic [31:0] sh_time_q, sh_date_q;
  logic [2:0] hs_cnt_q;
  logic load_cal, cal_run, sec_inc, in_setup;
  logic wr, wr_ok, wr_setup_ok, hit;
  logic [31:0] rdata_d, prdata_q;
  logic [7:0] sec_v, min_v, wday_v, mon_v, year_v;
  logic sec_wrap, min_wrap, mon_wrap;
  logic [7:0] hour_q, hour_d, date_q;
  logic pm_q, pm_d, day_carry, date_end, hour_up, hour_down;

  // ==========================================
  // source clock pins: three-stage sampling
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_q <= 3'h0;
      sync2_q <= 3'h0;
      sync3_q <= 3'h0;
      lvl_q <= 3'h0;
    end
    else
    begin
      sync1_q <= {hse_clk, lsi_clk, lse_clk};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      lvl_q <= lvl_d;
    end
  end

  // a level counts only once stages two and three agree
  assign lvl_d = (~(sync2_q ^ sync3_q) & sync3_q) | ((sync2_q ^ sync3_q) & lvl_q);
  assign rise = lvl_d & ~lvl_q;

  // ==========================================
  // source selection and high-speed pre-divider
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hse_cnt_q <= 5'h0;
    end
    else if (src_sel_q != rtcbcd_pkg::SRC_HSE)
    begin
      hse_cnt_q <= 5'h0;
    end
    else if (rise[2])
    begin
      hse_cnt_q <= (hse_cnt_q >= hse_div_q) ? 5'h0 : hse_cnt_q + 5'h1;
    end
  end

  always_comb
  begin
    unique case (src_sel_q)
      rtcbcd_pkg::SRC_LSE: src_tick = rise[0];
      rtcbcd_pkg::SRC_LSI: src_tick = rise[1];
      rtcbcd_pkg::SRC_HSE: src_tick = rise[2] && (hse_cnt_q >= hse_div_q);
      default: src_tick = 1'b0;
    endcase
  end

  // ==========================================
  // prescalers; held at their dividers while in setup
  assign in_setup = (state_q == rtcbcd_pkg::ST_SETUP);
  assign async_tick = src_tick && (async_cnt_q == 7'h0);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      async_cnt_q <= rtcbcd_pkg::ASYNC_DIV_RST;
    end
    else if (in_setup || async_tick)
    begin
      async_cnt_q <= async_div_q;
    end
    else if (src_tick)
    begin
      async_cnt_q <= async_cnt_q - 7'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_cnt_q <= rtcbcd_pkg::SYNC_DIV_RST;
    end
    else if (in_setup || (async_tick && sync_cnt_q == 15'h0))
    begin
      sync_cnt_q <= sync_div_q;
    end
    else if (async_tick)
    begin
      sync_cnt_q <= sync_cnt_q - 15'h1;
    end
  end

  // binary down-counter on the async tick
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      bin_cnt_q <= rtcbcd_pkg::BIN_RELOAD;
    end
    else if (in_setup)
    begin
      bin_cnt_q <= rtcbcd_pkg::BIN_RELOAD;
    end
    else if (async_tick && bin_sel_q != rtcbcd_pkg::BIN_OFF)
    begin
      bin_cnt_q <= (bin_cnt_q == 32'h0) ? rtcbcd_pkg::BIN_RELOAD : bin_cnt_q - 32'h1;
    end
  end

  // mixed mode: a second passes when the low bits of the counter are zero
  assign mix_mask = ~(rtcbcd_pkg::BIN_RELOAD << (rtcbcd_pkg::MIX_BASE + {3'h0, mix_sel_q}));
  assign mix_tick = async_tick && ((bin_cnt_q & mix_mask) == 32'h0);

  always_comb
  begin
    if (bin_sel_q == rtcbcd_pkg::BIN_OFF)
    begin
      one_hz_tick = async_tick && (sync_cnt_q == 15'h0);
    end
    else
    begin
      one_hz_tick = mix_tick;
    end
  end

  // calendar counts only on the one-second tick or an hour adjust; all of it is clocked by pclk
  assign cal_run = (state_q == rtcbcd_pkg::ST_RUN) && !init_q
    && (bin_sel_q != rtcbcd_pkg::BIN_ONLY);
  assign sec_inc = cal_run && one_hz_tick;

  // ==========================================
  // setup handshake
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= rtcbcd_pkg::ST_RUN;
      hs_cnt_q <= 3'h0;
    end
    else
    begin
      unique case (state_q)
        rtcbcd_pkg::ST_RUN:
        begin
          hs_cnt_q <= 3'h0;
          if (init_q)
          begin
            state_q <= rtcbcd_pkg::ST_ENTER;
          end
        end
        rtcbcd_pkg::ST_ENTER:
        begin
          if (!init_q)
          begin
            state_q <= rtcbcd_pkg::ST_RUN;
          end
          else if (low_power_calib_select_q ? async_tick : src_tick)
          begin
            hs_cnt_q <= hs_cnt_q + 3'h1;
            if (hs_cnt_q + 3'h1 == rtcbcd_pkg::ENTER_TICKS)
            begin
              state_q <= rtcbcd_pkg::ST_SETUP;
            end
          end
        end
        rtcbcd_pkg::ST_SETUP:
        begin
          hs_cnt_q <= 3'h0;
          if (!init_q)
          begin
            state_q <= rtcbcd_pkg::ST_LEAVE;
          end
        end
        rtcbcd_pkg::ST_LEAVE:
        begin
          if (load_cal)
          begin
            state_q <= rtcbcd_pkg::ST_RUN;
          end
          else if (src_tick && hs_cnt_q != rtcbcd_pkg::LEAVE_TICKS)
          begin
            hs_cnt_q <= hs_cnt_q + 3'h1;
          end
        end
      endcase
    end
  end

  // low-power calibration: two source ticks then one async tick
  assign load_cal = (state_q == rtcbcd_pkg::ST_LEAVE) && (low_power_calib_select_q
    ? (hs_cnt_q >= rtcbcd_pkg::LEAVE_LP_TICKS && async_tick)
    : (hs_cnt_q == rtcbcd_pkg::LEAVE_TICKS));

  // ==========================================
  // apb access
  assign wr = psel && penable && pwrite;
  assign wr_ok = wr && unlocked_q;
  assign wr_setup_ok = wr_ok && in_setup;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign prdata = prdata_q;

  // write protection keys
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      unlocked_q <= 1'b0;
      key1_q <= 1'b0;
    end
    else if (wr && paddr == rtcbcd_pkg::ADDR_KEY)
    begin
      // any wrong byte, KEY_LOCK included, relocks
      unlocked_q <= key1_q && pwdata[7:0] == rtcbcd_pkg::KEY_SECOND;
      key1_q <= (pwdata[7:0] == rtcbcd_pkg::KEY_FIRST);
    end
  end

  // control and setup status registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      fmt_q <= 1'b0;
      src_sel_q <= rtcbcd_pkg::SRC_LSE;
      hse_div_q <= 5'h0;
      init_q <= 1'b0;
      low_power_calib_select_q <= 1'b0;
      bin_sel_q <= rtcbcd_pkg::BIN_OFF;
      mix_sel_q <= 3'h0;
    end
    else if (wr_ok && paddr == rtcbcd_pkg::ADDR_CTRL)
    begin
      fmt_q <= pwdata[rtcbcd_pkg::CTRL_FMT];
      src_sel_q <= pwdata[rtcbcd_pkg::CTRL_SRC_LSB +: 2];
      hse_div_q <= pwdata[rtcbcd_pkg::CTRL_HDIV_LSB +: 5];
    end
    else if (wr_ok && paddr == rtcbcd_pkg::ADDR_SETUP)
    begin
      init_q <= pwdata[rtcbcd_pkg::SET_INIT];
      low_power_calib_select_q <= pwdata[rtcbcd_pkg::SET_LOW_POWER_CALIB_SELECT];
      // mode fields only take effect while stopped
      if (in_setup)
      begin
        bin_sel_q <= pwdata[rtcbcd_pkg::SET_BIN_LSB +: 2];
        mix_sel_q <= pwdata[rtcbcd_pkg::SET_MIX_LSB +: 3];
      end
    end
  end

  // hour adjust strobes clear themselves; dropped unless counting
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      add1h_q <= 1'b0;
      sub1h_q <= 1'b0;
    end
    else
    begin
      add1h_q <= wr_ok && paddr == rtcbcd_pkg::ADDR_CTRL && pwdata[rtcbcd_pkg::CTRL_ADD1H];
      sub1h_q <= wr_ok && paddr == rtcbcd_pkg::ADDR_CTRL && pwdata[rtcbcd_pkg::CTRL_SUB1H];
    end
  end

  // prescaler and shadow time/date
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_div_q <= rtcbcd_pkg::SYNC_DIV_RST;
      async_div_q <= rtcbcd_pkg::ASYNC_DIV_RST;
      sh_time_q <= 32'h0;
      sh_date_q <= 32'h0;
      sh_date_q[rtcbcd_pkg::D_DATE_LSB +: 6] <= rtcbcd_pkg::DATE_MIN[5:0];
      sh_date_q[rtcbcd_pkg::D_MON_LSB +: 5] <= rtcbcd_pkg::MON_MIN[4:0];
      sh_date_q[rtcbcd_pkg::D_WDAY_LSB +: 3] <= rtcbcd_pkg::WDAY_MIN[2:0];
    end
    else if (wr_setup_ok && paddr == rtcbcd_pkg::ADDR_PRESC)
    begin
      sync_div_q <= pwdata[rtcbcd_pkg::PRE_SYNC_LSB +: 15];
      // zero is out of range for the async divider and is refused
      if (pwdata[rtcbcd_pkg::PRE_ASYNC_LSB +: 7] >= rtcbcd_pkg::ASYNC_DIV_MIN)
      begin
        async_div_q <= pwdata[rtcbcd_pkg::PRE_ASYNC_LSB +: 7];
      end
    end
    else if (wr_setup_ok && paddr == rtcbcd_pkg::ADDR_TIME)
    begin
      sh_time_q <= pwdata & 32'h007F_7F7F;
    end
    else if (wr_setup_ok && paddr == rtcbcd_pkg::ADDR_DATE)
    begin
      sh_date_q <= pwdata & 32'h00FF_FF3F;
    end
  end

  // ==========================================
  // calendar counters
  rtcbcd_bcd_cnt #(.MINV(rtcbcd_pkg::BCD_ZERO), .MAXV(rtcbcd_pkg::MINSEC_MAX)) u_sec (
    .pclk(pclk), .presetn(presetn), .load(load_cal),
    .load_val({1'b0, sh_time_q[rtcbcd_pkg::T_SEC_LSB +: 7]}),
    .inc(sec_inc), .value_q(sec_v), .wrap(sec_wrap));

  rtcbcd_bcd_cnt #(.MINV(rtcbcd_pkg::BCD_ZERO), .MAXV(rtcbcd_pkg::MINSEC_MAX)) u_min (
    .pclk(pclk), .presetn(presetn), .load(load_cal),
    .load_val({1'b0, sh_time_q[rtcbcd_pkg::T_MIN_LSB +: 7]}),
    .inc(sec_wrap), .value_q(min_v), .wrap(min_wrap));

  rtcbcd_bcd_cnt #(.MINV(rtcbcd_pkg::WDAY_MIN), .MAXV(rtcbcd_pkg::WDAY_MAX)) u_wday (
    .pclk(pclk), .presetn(presetn), .load(load_cal),
    .load_val({5'h0, sh_date_q[rtcbcd_pkg::D_WDAY_LSB +: 3]}),
    .inc(day_carry), .value_q(wday_v), .wrap());

  rtcbcd_bcd_cnt #(.MINV(rtcbcd_pkg::MON_MIN), .MAXV(rtcbcd_pkg::MON_MAX)) u_mon (
    .pclk(pclk), .presetn(presetn), .load(load_cal),
    .load_val({3'h0, sh_date_q[rtcbcd_pkg::D_MON_LSB +: 5]}),
    .inc(day_carry && date_end), .value_q(mon_v), .wrap(mon_wrap));

  rtcbcd_bcd_cnt #(.MINV(rtcbcd_pkg::BCD_ZERO), .MAXV(rtcbcd_pkg::YEAR_MAX)) u_year (
    .pclk(pclk), .presetn(presetn), .load(load_cal),
    .load_val(sh_date_q[rtcbcd_pkg::D_YEAR_LSB +: 8]),
    .inc(mon_wrap), .value_q(year_v), .wrap());

  // hours, with 12h/24h format and daylight adjust
  assign hour_up = cal_run && (min_wrap || add1h_q);
  assign hour_down = cal_run && sub1h_q && !hour_up;

  always_comb
  begin
    hour_d = hour_q;
    pm_d = pm_q;
    day_carry = 1'b0;
    if (load_cal)
    begin
      hour_d = {2'h0, sh_time_q[rtcbcd_pkg::T_HOUR_LSB +: 6]};
      pm_d = fmt_q && sh_time_q[rtcbcd_pkg::T_PM];
    end
    else if (hour_up && !fmt_q)
    begin
      day_carry = (hour_q == rtcbcd_pkg::HOUR24_MAX);
      hour_d = day_carry ? rtcbcd_pkg::BCD_ZERO : rtcbcd_pkg::bcd_inc(hour_q);
    end
    else if (hour_up)
    begin
      if (hour_q == rtcbcd_pkg::HOUR12_MAX)
      begin
        hour_d = rtcbcd_pkg::HOUR12_FIRST;
      end
      else if (hour_q == rtcbcd_pkg::HOUR12_LAST)
      begin
        hour_d = rtcbcd_pkg::HOUR12_MAX;
        pm_d = !pm_q;
        day_carry = pm_q;
      end
      else
      begin
        hour_d = rtcbcd_pkg::bcd_inc(hour_q);
      end
    end
    else if (hour_down)
    begin
      // the first hour of the day is not wound back
      if (!fmt_q)
      begin
        hour_d = (hour_q == rtcbcd_pkg::BCD_ZERO) ? hour_q : rtcbcd_pkg::bcd_dec(hour_q);
      end
      else if (hour_q == rtcbcd_pkg::HOUR12_FIRST)
      begin
        hour_d = rtcbcd_pkg::HOUR12_MAX;
      end
      else if (hour_q == rtcbcd_pkg::HOUR12_MAX)
      begin
        hour_d = pm_q ? rtcbcd_pkg::HOUR12_LAST : hour_q;
        pm_d = 1'b0;
      end
      else
      begin
        hour_d = rtcbcd_pkg::bcd_dec(hour_q);
      end
    end
  end

  assign date_end = (date_q == rtcbcd_pkg::month_last(mon_v, year_v));

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hour_q <= rtcbcd_pkg::BCD_ZERO;
      pm_q <= 1'b0;
      date_q <= rtcbcd_pkg::DATE_MIN;
    end
    else
    begin
      hour_q <= hour_d;
      pm_q <= pm_d;
      if (load_cal)
      begin
        date_q <= {2'h0, sh_date_q[rtcbcd_pkg::D_DATE_LSB +: 6]};
      end
      else if (day_carry)
      begin
        date_q <= date_end ? rtcbcd_pkg::DATE_MIN : rtcbcd_pkg::bcd_inc(date_q);
      end
    end
  end

  // ==========================================
  // read path; data is captured in the setup phase
  always_comb
  begin
    rdata_d = 32'h0;
    hit = 1'b1;
    unique case (paddr)
      rtcbcd_pkg::ADDR_TIME:
      begin
        rdata_d[rtcbcd_pkg::T_SEC_LSB +: 7] = sec_v[6:0];
        rdata_d[rtcbcd_pkg::T_MIN_LSB +: 7] = min_v[6:0];
        rdata_d[rtcbcd_pkg::T_HOUR_LSB +: 6] = hour_q[5:0];
        rdata_d[rtcbcd_pkg::T_PM] = pm_q;
      end
      rtcbcd_pkg::ADDR_DATE:
      begin
        rdata_d[rtcbcd_pkg::D_DATE_LSB +: 6] = date_q[5:0];
        rdata_d[rtcbcd_pkg::D_MON_LSB +: 5] = mon_v[4:0];
        rdata_d[rtcbcd_pkg::D_WDAY_LSB +: 3] = wday_v[2:0];
        rdata_d[rtcbcd_pkg::D_YEAR_LSB +: 8] = year_v;
      end
      rtcbcd_pkg::ADDR_SUBSEC:
      begin
        rdata_d = (bin_sel_q != rtcbcd_pkg::BIN_OFF) ? bin_cnt_q
          : {17'h0, sync_cnt_q};
      end
      rtcbcd_pkg::ADDR_CTRL:
      begin
        rdata_d[rtcbcd_pkg::CTRL_FMT] = fmt_q;
        rdata_d[rtcbcd_pkg::CTRL_SRC_LSB +: 2] = src_sel_q;
        rdata_d[rtcbcd_pkg::CTRL_HDIV_LSB +: 5] = hse_div_q;
      end
      rtcbcd_pkg::ADDR_SETUP:
      begin
        rdata_d[rtcbcd_pkg::SET_INIT] = init_q;
        rdata_d[rtcbcd_pkg::SET_FLAG] = in_setup;
        rdata_d[rtcbcd_pkg::SET_LOW_POWER_CALIB_SELECT] = low_power_calib_select_q;
        rdata_d[rtcbcd_pkg::SET_UNLOCK] = unlocked_q;
        rdata_d[rtcbcd_pkg::SET_BIN_LSB +: 2] = bin_sel_q;
        rdata_d[rtcbcd_pkg::SET_MIX_LSB +: 3] = mix_sel_q;
      end
      rtcbcd_pkg::ADDR_PRESC:
      begin
        rdata_d[rtcbcd_pkg::PRE_SYNC_LSB +: 15] = sync_div_q;
        rdata_d[rtcbcd_pkg::PRE_ASYNC_LSB +: 7] = async_div_q;
      end
      rtcbcd_pkg::ADDR_KEY: rdata_d = 32'h0;
      default: hit = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h0;
    end
    else if (psel && !penable && !pwrite)
    begin
      prdata_q <= rdata_d;
    end
  end
endmodule

/* File: test/rtcbcd_core_properties.sv */
`timescale 1ns/100ps
// ==========================================
// port checker
module rtcbcd_core_chk (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // sources and tick
  input wire logic lse_clk,
  input wire logic lsi_clk,
  input wire logic hse_clk,
  input wire logic one_hz_tick
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic acc;
  assign acc = psel && penable;
  chk_ready_always: assert property (pready) else $error("pready low");
  chk_err_unmapped: assert property (acc && paddr > 8'h18 |-> pslverr)
    else $error("no error on unmapped address");
  chk_err_mapped: assert property (acc && paddr <= 8'h18 && paddr[1:0] == 2'b00 |-> !pslverr)
    else $error("error on mapped address");
  chk_err_phase: assert property (pslverr |-> acc) else $error("error outside access");
  chk_key_reads_zero: assert property (acc && !pwrite && paddr == 8'h18 |-> prdata == '0)
    else $error("key register read not zero");
  chk_tick_pulse_gap: assert property (one_hz_tick |=> !one_hz_tick [*3])
    else $error("tick too long or too close");
  chk_rdata_cause: assert property ($changed(prdata) |-> $past(psel) && !$past(penable)
    && !$past(pwrite))
    else $error("read data moved without read setup");
  chk_rdata_hold: assert property (acc && !pwrite |=> $stable(prdata))
    else $error("read data moved after access");
  cover property (acc && pwrite && paddr == 8'h18);
  cover property (one_hz_tick);
  cover property (pslverr);
endmodule
bind rtcbcd_core rtcbcd_core_chk i_rtcbcd_core_chk (.pclk, .presetn, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .lse_clk, .lsi_clk, .hse_clk,
  .one_hz_tick);

/* File: test/rtcbcd_core_tb.sv */
`timescale 1ns/100ps
module rtcbcd_core_tb;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic lse_clk = 0, lsi_clk = 0, hse_clk = 0, pready, pslverr, one_hz_tick, e;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000, prdata, r;
  logic [2:0] div = 3'h0;
  int error_cnt = 0, checked = 0, n;
  rtcbcd_core i_rtcbcd_core (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .lse_clk, .lsi_clk, .hse_clk, .one_hz_tick);
  initial forever #25 pclk = ~pclk;
  // slow source, eight pclk per period
  always @(posedge pclk)
    {lse_clk, div} <= {div[2], div + 3'h1};
  // ==========================================
  // tasks
  task finish_test;
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task cmp(input string s, input logic [31:0] x, input logic [31:0] y);
    checked++;
    if (y !== x)
    begin
      error_cnt++;
      $display("BAD %s exp %h got %h", s, x, y);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      error_cnt++;
      finish_test;
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rd(input logic [7:0] a, input logic [31:0] x, input string s);
    apb(1'b0, a, 32'h0000_0000);
    cmp(s, x, r);
  endtask
  // load a time and date just before midnight, then one second must roll the day
  task roll(input logic [31:0] tm, input logic [31:0] xt, input logic [31:0] dt,
    input logic [31:0] xd);
    int i;
    apb(1'b1, rtcbcd_pkg::ADDR_SETUP, 32'h0000_0001);
    r = 32'h0000_0000;
    for (i = 0; i < 40 && r[1] !== 1'b1; i++)
      apb(1'b0, rtcbcd_pkg::ADDR_SETUP, 32'h0000_0000);
    cmp("flag", 32'h0000_0001, {31'h0, r[1]});
    if (r[1] !== 1'b1)
      finish_test;
    apb(1'b1, rtcbcd_pkg::ADDR_PRESC, 32'h0001_0000);
    apb(1'b1, rtcbcd_pkg::ADDR_TIME, tm);
    apb(1'b1, rtcbcd_pkg::ADDR_DATE, dt);
    apb(1'b1, rtcbcd_pkg::ADDR_SETUP, 32'h0000_0000);
    // ticks during the four-source-cycle reload do not move the calendar
    repeat (36) @(posedge pclk);
    for (i = 0; i < 2000 && one_hz_tick !== 1'b1; i++)
      @(negedge pclk);
    cmp("tick", 32'h0000_0001, {31'h0, one_hz_tick});
    if (one_hz_tick !== 1'b1)
      finish_test;
    @(posedge pclk);
    rd(rtcbcd_pkg::ADDR_TIME, xt, "time");
    rd(rtcbcd_pkg::ADDR_DATE, xd, "date");
  endtask
  // ==========================================
  // main sequence
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(rtcbcd_pkg::ADDR_PRESC, 32'h007F_00FF, "presc");
    rd(rtcbcd_pkg::ADDR_DATE, 32'h0000_2101, "date");
    apb(1'b1, rtcbcd_pkg::ADDR_CTRL, 32'h0000_0011);
    rd(rtcbcd_pkg::ADDR_CTRL, 32'h0000_0010, "ctrl");
    apb(1'b0, 8'h1C, 32'h0000_0000);
    cmp("pslverr", 32'h0000_0001, {31'h0, e});
    $display("test reset done");
    apb(1'b1, rtcbcd_pkg::ADDR_KEY, {24'h0, rtcbcd_pkg::KEY_FIRST});
    apb(1'b1, rtcbcd_pkg::ADDR_KEY, {24'h0, rtcbcd_pkg::KEY_SECOND});
    apb(1'b0, rtcbcd_pkg::ADDR_SETUP, 32'h0000_0000);
    cmp("unlock", 32'h0000_0001, {31'h0, r[3]});
    rd(rtcbcd_pkg::ADDR_KEY, 32'h0000_0000, "key");
    roll(32'h0023_5959, 32'h0000_0000, 32'h0001_2228, 32'h0001_4301);
    roll(32'h0023_5959, 32'h0000_0000, 32'h0004_E228, 32'h0004_2229);
    roll(32'h0023_5959, 32'h0000_0000, 32'h0000_6430, 32'h0000_8501);
    $display("test calendar done");
    // 12h: 11:59:59 PM rolls to 12 AM of the next day, then one hour up and down
    apb(1'b1, rtcbcd_pkg::ADDR_CTRL, 32'h0000_0011);
    roll(32'h0051_5959, 32'h0012_0000, 32'h0000_6430, 32'h0000_8501);
    apb(1'b1, rtcbcd_pkg::ADDR_CTRL, 32'h0000_0013);
    apb(1'b0, rtcbcd_pkg::ADDR_TIME, 32'h0000_0000);
    cmp("add hour", 32'h0000_0001, {24'h0, r[23:16]});
    apb(1'b1, rtcbcd_pkg::ADDR_CTRL, 32'h0000_0015);
    apb(1'b0, rtcbcd_pkg::ADDR_TIME, 32'h0000_0000);
    cmp("sub hour", 32'h0000_0012, {24'h0, r[23:16]});
    $display("test hours done");
    // binary mode: subsecond shows the down-counter, calendar stays on its load
    apb(1'b1, rtcbcd_pkg::ADDR_SETUP, 32'h0000_0001);
    repeat (40) @(posedge pclk);
    rd(rtcbcd_pkg::ADDR_SETUP, 32'h0000_000B, "setup flag");
    apb(1'b1, rtcbcd_pkg::ADDR_PRESC, 32'h0001_0005);
    rd(rtcbcd_pkg::ADDR_SUBSEC, 32'h0000_0005, "subsec");
    apb(1'b1, rtcbcd_pkg::ADDR_SETUP, 32'h0000_0011);
    rd(rtcbcd_pkg::ADDR_SUBSEC, 32'hFFFF_FFFF, "bin subsec");
    apb(1'b1, rtcbcd_pkg::ADDR_SETUP, 32'h0000_0010);
    repeat (200) @(posedge pclk);
    rd(rtcbcd_pkg::ADDR_TIME, 32'h0051_5959, "bin time");
    $display("test binary done");
    apb(1'b1, rtcbcd_pkg::ADDR_KEY, {24'h0, rtcbcd_pkg::KEY_LOCK});
    apb(1'b0, rtcbcd_pkg::ADDR_SETUP, 32'h0000_0000);
    cmp("relock", 32'h0000_0000, {31'h0, r[3]});
    $display("test relock done");
    finish_test;
  end
endmodule
